// *** hdl/cdc_pkg.sv ***
// Shared constants and types for the cable driver control block.
package cdc_pkg;
  // Timing of the signal-presence edge-energy window.
  localparam int CLK_NS = 10;
  localparam int DET_WIN_NS = 1000;
  localparam int DET_WIN_CYC = DET_WIN_NS / CLK_NS;
  localparam logic [7:0] DET_MIN_EDGES = 8'h08;
  localparam int SYNC_LAT = 3;
  // Command word fields.
  localparam int WORD_W = 16;
  localparam int CMD_RD_BIT = 15;
  localparam int CMD_BCAST_BIT = 14;
  localparam int CMD_EXT_BIT = 13;
  localparam int CMD_STEP_BIT = 12;
  localparam int CMD_UNIT_HI = 11;
  localparam int CMD_UNIT_LO = 7;
  localparam int CMD_ADDR_HI = 6;
  // Register addresses and control field positions.
  localparam logic [6:0] REG_CTRL = 7'h00;
  localparam logic [6:0] REG_STAT = 7'h01;
  localparam int CTRL_UNIT_LO = 0;
  localparam int CTRL_MODE_LO = 5;
  localparam int CTRL_SWSEL_BIT = 7;
  localparam int CTRL_SWHIGH_BIT = 8;
  localparam logic [4:0] UNIT_RST = 5'h00;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [3:0] BIT_LAST = 4'hF;
  typedef enum logic [1:0] {
    MODE_LOOP = 2'b00,
    MODE_QUIET = 2'b01,
    MODE_BUS = 2'b10
  } cdc_chain_t;
  typedef enum logic [1:0] {
    PH_CMD = 2'b00,
    PH_EXT = 2'b01,
    PH_DATA = 2'b10
  } cdc_phase_t;
  function automatic logic [4:0] cmd_unit(input logic [15:0] w);
    return w[CMD_UNIT_HI:CMD_UNIT_LO];
  endfunction : cmd_unit
  function automatic logic [6:0] cmd_addr(input logic [15:0] w);
    return w[CMD_ADDR_HI:0];
  endfunction : cmd_addr
endpackage : cdc_pkg

// *** hdl/cdc_det_if.sv ***
// Carrier between the control core and the edge-energy detector.
`timescale 1ns/1ns
interface cdc_det_if;
  logic edge_in;
  logic present;
  modport det (input edge_in, output present);
  modport core (output edge_in, input present);
endinterface : cdc_det_if

// *** hdl/cdc_sync.sv ***
// Two-flop level synchroniser, one per bit.
`timescale 1ns/1ns
module cdc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : cdc_sync

// *** hdl/cdc_edge_det.sv ***
// Edge-energy detector that reports whether the pre-driver is toggling.
`timescale 1ns/1ns
module cdc_edge_det (
  input wire logic clk,
  input wire logic rst_n,
  cdc_det_if.det dif
);
  import cdc_pkg::*;
  logic prev_q;
  logic [15:0] win_q;
  logic [7:0] edges_q;
  logic present_q;
  logic win_end;
  logic toggle;

  assign win_end = (win_q == 16'(DET_WIN_CYC - 1));
  assign toggle = dif.edge_in ^ prev_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= 1'b0;
      win_q <= 16'h0000;
    end else begin
      prev_q <= dif.edge_in;
      win_q <= win_end ? 16'h0000 : win_q + 16'h0001;
    end
  end

  // Edges are counted over a fixed window, so one glitch cannot raise presence.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      edges_q <= 8'h00;
      present_q <= 1'b0;
    end else if (win_end) begin
      edges_q <= 8'h00;
      present_q <= (edges_q >= DET_MIN_EDGES);
    end else if (toggle && edges_q != 8'hFF) begin
      edges_q <= edges_q + 8'h01;
    end
  end

  assign dif.present = present_q;

  chk_presence_update: assert property (
    @(posedge clk) disable iff (!rst_n)
    win_end |=> (present_q == ($past(edges_q) >= DET_MIN_EDGES)))
    else $error("presence flag disagrees with edge count");
endmodule : cdc_edge_det

// *** hdl/cdc_ctrl.sv ***
// Cable driver pin control, signal presence and serial host port.
`timescale 1ns/1ns
module cdc_ctrl (
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic TRACE_BOOST_ON,
  input wire logic SLOW_EDGE_SELECT,
  input wire logic DRIVE_ONE_ON,
  input wire logic DRIVE_TWO_ON,
  input wire logic SWING_HIGH_PIN,
  input wire logic DIFF_DATA_IN,
  output logic TRACE_BOOST_EN,
  output logic SLOW_EDGE_EN,
  output logic DRIVE_ONE_EN,
  output logic DRIVE_TWO_EN,
  output logic LOW_POWER,
  output logic SWING_HIGH,
  output logic SIGNAL_PRESENT,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic SDI,
  output logic SDO_DATA,
  output logic SDO_OE_N
);
  import cdc_pkg::*;

  // Core clock domain: pin controls and signal presence.
  logic [5:0] pins_s;
  logic [1:0] swcfg_s;
  logic boost_q;
  logic slow_q;
  logic one_q;
  logic two_q;
  logic lowp_q;
  logic swing_q;
  logic [1:0] up_q;
  cdc_det_if dif ();

  cdc_sync #(.W(6)) u_pin_sync (
    .clk(MCLK),
    .rst_n(RSTN),
    .d({DIFF_DATA_IN, SWING_HIGH_PIN, DRIVE_TWO_ON, DRIVE_ONE_ON,
        SLOW_EDGE_SELECT, TRACE_BOOST_ON}),
    .q(pins_s)
  );

  assign dif.edge_in = pins_s[5];

  cdc_edge_det u_det (
    .clk(MCLK),
    .rst_n(RSTN),
    .dif(dif)
  );

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      boost_q <= 1'b0;
      slow_q <= 1'b0;
    end else begin
      // Boost is not gated by slow edges; keeping them apart is the host's job.
      boost_q <= pins_s[0];
      slow_q <= pins_s[1];
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      one_q <= 1'b0;
      two_q <= 1'b0;
      lowp_q <= 1'b1;
    end else begin
      one_q <= pins_s[2];
      two_q <= pins_s[3];
      lowp_q <= !pins_s[2] && !pins_s[3];
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      swing_q <= 1'b0;
    end else begin
      swing_q <= swcfg_s[0] ? swcfg_s[1] : pins_s[4];
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      up_q <= 2'h0;
    end else if (up_q != 2'h3) begin
      up_q <= up_q + 2'h1;
    end
  end

  assign TRACE_BOOST_EN = boost_q;
  assign SLOW_EDGE_EN = slow_q;
  assign DRIVE_ONE_EN = one_q;
  assign DRIVE_TWO_EN = two_q;
  assign LOW_POWER = lowp_q;
  assign SWING_HIGH = swing_q;
  assign SIGNAL_PRESENT = dif.present;

  // Link clock domain: serial host port.
  cdc_phase_t phase_q;
  logic [3:0] bit_q;
  logic [14:0] shin_q;
  logic [15:0] cmd_q;
  logic [6:0] addr_q;
  logic [4:0] unit_q;
  cdc_chain_t mode_q;
  logic swsel_q;
  logic swhigh_q;
  logic [15:0] tx_q;
  logic [6:0] stat_s;
  logic frame_rst_n;
  logic [15:0] word;
  logic word_done;
  logic hit;
  logic reading;
  logic wr_en;
  logic [15:0] ctrl_word;
  logic [15:0] rdata;

  // Raising the select ends the frame at once, with no clock edge needed.
  assign frame_rst_n = RSTN && !CS_N;
  assign word = {shin_q, SDI};
  assign word_done = (bit_q == BIT_LAST);
  assign hit = (cmd_unit(cmd_q) == unit_q);
  assign reading = (phase_q == PH_DATA) && cmd_q[CMD_RD_BIT] && hit;
  assign wr_en = word_done && (phase_q == PH_DATA) && !cmd_q[CMD_RD_BIT]
                 && (hit || cmd_q[CMD_BCAST_BIT]);
  assign ctrl_word = {7'h00, swhigh_q, swsel_q, mode_q, unit_q};

  cdc_sync #(.W(7)) u_stat_sync (
    .clk(SCLK),
    .rst_n(RSTN),
    .d({dif.present, lowp_q, two_q, one_q, slow_q, boost_q, swing_q}),
    .q(stat_s)
  );

  cdc_sync #(.W(2)) u_cfg_sync (
    .clk(MCLK),
    .rst_n(RSTN),
    .d({swhigh_q, swsel_q}),
    .q(swcfg_s)
  );

  always_comb begin
    unique case (addr_q)
      REG_CTRL: rdata = ctrl_word;
      REG_STAT: rdata = {9'h000, stat_s};
      default: rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge SCLK or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_q <= 4'h0;
      shin_q <= 15'h0000;
    end else begin
      bit_q <= bit_q + 4'h1;
      shin_q <= word[14:0];
    end
  end

  always_ff @(posedge SCLK or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      phase_q <= PH_CMD;
      cmd_q <= 16'h0000;
      addr_q <= 7'h00;
    end else if (word_done) begin
      unique case (phase_q)
        PH_CMD: begin
          cmd_q <= word;
          addr_q <= cmd_addr(word);
          phase_q <= word[CMD_EXT_BIT] ? PH_EXT : PH_DATA;
        end
        // Upper address bits are accepted and dropped: only 128 registers exist.
        PH_EXT: phase_q <= PH_DATA;
        PH_DATA: begin
          if (cmd_q[CMD_STEP_BIT]) begin
            addr_q <= addr_q + 7'h01;
          end
        end
        default: phase_q <= PH_CMD;
      endcase
    end
  end

  always_ff @(posedge SCLK or negedge RSTN) begin
    if (!RSTN) begin
      unit_q <= UNIT_RST;
      mode_q <= cdc_chain_t'(MODE_RST);
      swsel_q <= 1'b0;
      swhigh_q <= 1'b0;
    end else if (wr_en && addr_q == REG_CTRL) begin
      unit_q <= word[CTRL_UNIT_LO +: 5];
      mode_q <= cdc_chain_t'(word[CTRL_MODE_LO +: 2]);
      swsel_q <= word[CTRL_SWSEL_BIT];
      swhigh_q <= word[CTRL_SWHIGH_BIT];
    end
  end

  // Read words load on the falling edge that follows the last bit before them.
  always_ff @(negedge SCLK or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      tx_q <= 16'h0000;
    end else if (bit_q == 4'h0) begin
      tx_q <= rdata;
    end else begin
      tx_q <= {tx_q[14:0], 1'b0};
    end
  end

  // The pass-through path is combinational so chained parts see every edge.
  always_comb begin
    SDO_OE_N = 1'b0;
    SDO_DATA = SDI;
    if (reading && !CS_N) begin
      SDO_DATA = tx_q[15];
    end else if (mode_q == MODE_QUIET) begin
      SDO_DATA = 1'b1;
    end else if (mode_q == MODE_BUS && CS_N) begin
      SDO_OE_N = 1'b1;
      SDO_DATA = 1'b0;
    end
  end

  chk_boost_follow: assert property (
    @(posedge MCLK) disable iff (!RSTN)
    (up_q == 2'h3) |-> (TRACE_BOOST_EN == $past(TRACE_BOOST_ON, SYNC_LAT)))
    else $error("trace boost does not follow its pin");

  chk_slew_follow: assert property (
    @(posedge MCLK) disable iff (!RSTN)
    (up_q == 2'h3) |-> (SLOW_EDGE_EN == $past(SLOW_EDGE_SELECT, SYNC_LAT)))
    else $error("edge rate does not follow its pin");

  chk_drive_follow: assert property (
    @(posedge MCLK) disable iff (!RSTN)
    (up_q == 2'h3) |-> (DRIVE_ONE_EN == $past(DRIVE_ONE_ON, SYNC_LAT))
    && (DRIVE_TWO_EN == $past(DRIVE_TWO_ON, SYNC_LAT)))
    else $error("driver enable does not follow its pin");

  chk_low_power: assert property (
    @(posedge MCLK) disable iff (!RSTN)
    (up_q == 2'h3) |->
    (LOW_POWER == (!$past(DRIVE_ONE_ON, SYNC_LAT) && !$past(DRIVE_TWO_ON, SYNC_LAT))))
    else $error("low power disagrees with driver enables");

  chk_swing_select: assert property (
    @(posedge MCLK) disable iff (!RSTN)
    ($stable(swcfg_s) && $stable(pins_s[4])) |=>
    (SWING_HIGH == ($past(swcfg_s[0]) ? $past(swcfg_s[1]) : $past(pins_s[4]))))
    else $error("swing range source is wrong");

  chk_loop_copy: assert property (
    @(posedge SCLK) disable iff (!RSTN)
    (mode_q == MODE_LOOP && !reading) |-> (SDO_DATA == SDI && !SDO_OE_N))
    else $error("loop-through output is not a copy of input");

  chk_bus_float: assert property (
    @(posedge MCLK) disable iff (!RSTN)
    (mode_q == MODE_BUS && CS_N) |-> SDO_OE_N)
    else $error("bus-through output driven while deselected");

  sequence seq_cmd_word;
    (!CS_N && phase_q == PH_CMD && word_done);
  endsequence

  sequence seq_data_word;
    (!CS_N && phase_q == PH_DATA && word_done);
  endsequence

  chk_step_addr: assert property (
    @(posedge SCLK) disable iff (!RSTN)
    seq_data_word ##1 (!CS_N && cmd_q[CMD_STEP_BIT])
    |-> (addr_q == $past(addr_q) + 7'h01))
    else $error("address did not step after a burst word");

  chk_cmd_fields: assert property (
    @(posedge SCLK) disable iff (!RSTN)
    seq_cmd_word ##1 !CS_N |-> (addr_q == cmd_addr(cmd_q)
    && phase_q == (cmd_q[CMD_EXT_BIT] ? PH_EXT : PH_DATA)))
    else $error("command word fields decoded wrongly");

  chk_write_gate: assert property (
    @(posedge SCLK) disable iff (!RSTN)
    (word_done && phase_q == PH_DATA && !CS_N && !cmd_q[CMD_BCAST_BIT]
     && !hit) |=> $stable(ctrl_word))
    else $error("write taken for another unit");
endmodule : cdc_ctrl

// *** bench/cdc_host_model.sv ***
// Host-side serial master model that runs frames on the link clock.
`timescale 1ns/1ns
module cdc_host_model (
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo
);
  logic [15:0] rd_word;
  event rd_ev;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
    rd_word = 16'h0000;
  end
  // The clock stands low outside frames; select covers whole words only.
  task automatic xfer(input logic [15:0] cmd, input logic [15:0] wd, input int nw);
    logic [15:0] w;
    #3;
    cs_n = 1'b0;
    for (int i = 0; i < 16 * (nw + 1); i++) begin
      w = (i < 16) ? cmd : wd;
      sdi = w[15 - i % 16];
      #32;
      sclk = 1'b1;
      if (i >= 16) begin
        rd_word[15 - i % 16] = sdo;
      end
      if (cmd[15] && i >= 16 && i % 16 == 15) begin
        -> rd_ev;
      end
      #32;
      sclk = 1'b0;
    end
    #32;
    cs_n = 1'b1;
    // A released data line must not look like a held bit, so flip it.
    sdi = ~sdi;
  endtask : xfer
endmodule : cdc_host_model

// *** bench/tb_top.sv ***
// Self-checking bench for the cable driver control block.
`timescale 1ns/1ns
module tb_top;
  import cdc_pkg::*;
  logic mclk, rst_n, boost, slow, one, two, swing_pin, diff_data_in;
  logic boost_en, slow_en, one_en, two_en, low_pwr, swing_hi, sig_pres;
  logic sclk, cs_n, sdi, sdo_o, sdo_oe_n;
  wire sdo_w;
  int err_count = 0;
  int n_compared = 0;
  int seed = 32'h53E20E2A;
  logic [4:0] pv;
  logic [15:0] rnd;
  logic [17:0] pin_q[$];
  logic [15:0] word_q[$];
  event pin_ev;
  assign sdo_w = sdo_oe_n ? 1'bz : sdo_o;

  cdc_ctrl dut_u (.MCLK(mclk), .RSTN(rst_n), .TRACE_BOOST_ON(boost),
    .SLOW_EDGE_SELECT(slow), .DRIVE_ONE_ON(one), .DRIVE_TWO_ON(two),
    .SWING_HIGH_PIN(swing_pin), .DIFF_DATA_IN(diff_data_in), .TRACE_BOOST_EN(boost_en),
    .SLOW_EDGE_EN(slow_en), .DRIVE_ONE_EN(one_en), .DRIVE_TWO_EN(two_en),
    .LOW_POWER(low_pwr), .SWING_HIGH(swing_hi), .SIGNAL_PRESENT(sig_pres),
    .SCLK(sclk), .CS_N(cs_n), .SDI(sdi), .SDO_DATA(sdo_o), .SDO_OE_N(sdo_oe_n));
  cdc_host_model host_u (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo_w));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic cmp_pins(input logic [8:0] exp, input logic [8:0] got, input logic [8:0] msk);
    n_compared++;
    if (((got ^ exp) & msk) !== 9'h000) begin
      err_count++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : cmp_pins

  task automatic cmp_word(input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : cmp_word

  always @(pin_ev) begin : pin_mon
    logic [17:0] n;
    logic [8:0] got;
    n = pin_q.pop_front();
    got = {sdo_oe_n, sdo_o, sig_pres, low_pwr, two_en, one_en, slow_en, boost_en, swing_hi};
    cmp_pins(n[8:0], got, n[17:9]);
  end
  always @(host_u.rd_ev) cmp_word(word_q.pop_front(), host_u.rd_word);

  function automatic logic [6:0] expv(input logic [4:0] p, input logic sw, input logic sp);
    return {sp, ~p[2] & ~p[3], p[3], p[2], p[1], p[0], sw};
  endfunction : expv

  // Pin outputs sit behind a two-flop synchroniser and a register, so wait four edges.
  task automatic expect_pins(input logic [8:0] exp, input logic [8:0] msk);
    repeat (4) @(posedge mclk);
    #2;
    pin_q.push_back({msk, exp});
    -> pin_ev;
    #1;
  endtask : expect_pins

  task automatic chk(input logic sw, input logic sp);
    expect_pins({1'b0, sdi, expv(pv, sw, sp)}, 9'h1FF);
  endtask : chk

  task automatic drive(input logic [4:0] p);
    @(posedge mclk);
    {swing_pin, two, one, slow, boost} <= p;
    pv = p;
  endtask : drive

  task automatic toggle(input int gap, input int cycles);
    for (int c = 0; c < cycles; c++) begin
      @(posedge mclk);
      if (c % gap == 0) diff_data_in <= ~diff_data_in;
    end
  endtask : toggle

  task automatic do_reset();
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
  endtask : do_reset

  task automatic rd(input logic [15:0] cmd, input logic [15:0] exp);
    word_q.push_back(exp);
    host_u.xfer(cmd, 16'h0000, 1);
  endtask : rd

  task automatic tally_and_finish();
    err_count += word_q.size();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #200000;
    err_count++;
    tally_and_finish();
  end

  initial begin
    rst_n = 1'b0;
    diff_data_in = 1'b0;
    pv = 5'h00;
    {swing_pin, two, one, slow, boost} = 5'h00;
    do_reset();
    chk(1'b0, 1'b0);
    for (int i = 0; i < 32; i++) begin
      drive((i[1] ? 5'h1E : 5'h1F) & i[4:0]);
      chk(pv[4], 1'b0);
    end
    drive(5'h05);
    toggle(10, 300);
    chk(1'b0, 1'b1);
    toggle(20, 300);
    chk(1'b0, 1'b0);
    rd(16'h8001, {9'h000, expv(pv, 1'b0, 1'b0)});
    host_u.xfer(16'h0000, 16'h0185, 1);
    chk(1'b1, 1'b0);
    rnd = 16'($random(seed));
    word_q.push_back(rnd);
    host_u.xfer(16'h8000, rnd, 1);
    word_q.push_back(16'h0185);
    word_q.push_back({9'h000, expv(pv, 1'b1, 1'b0)});
    host_u.xfer(16'h9280, 16'h0000, 2);
    host_u.xfer(16'h4480, 16'h0005, 1);
    host_u.xfer(16'h0480, 16'h0185, 1);
    rd(16'h8280, 16'h0005);
    chk(1'b0, 1'b0);
    host_u.xfer(16'h1280, 16'h0045, 2);
    expect_pins({2'b10, expv(pv, 1'b0, 1'b0)}, 9'h17F);
    rd(16'h8280, 16'h0045);
    do_reset();
    chk(1'b0, 1'b0);
    rd(16'h8000, 16'h0000);
    // The extended address word is not a read word, so loop-through echoes it.
    word_q.push_back(16'h5A3C);
    word_q.push_back(16'h0000);
    host_u.xfer(16'hA000, 16'h5A3C, 2);
    host_u.xfer(16'h0000, 16'h0020, 1);
    expect_pins({2'b01, expv(pv, 1'b0, 1'b0)}, 9'h1FF);
    word_q.push_back(16'hFFFF);
    host_u.xfer(16'h8080, 16'h0000, 1);
    repeat (10) @(posedge mclk);
    tally_and_finish();
  end
endmodule : tb_top
